/* File: bfiu_chk_monitor.sv */
// Assertion checker for the bit and flag instruction unit
`timescale 1ns/1ps
`default_nettype none
module bfiu_chk_monitor
  import bfiu_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       resetn_in,
  input wire logic       op_valid_in,
  input wire logic [4:0] op_code_in,
  input wire logic [7:0] reg_data_in,
  input wire logic [7:0] io_data_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] stack_data_in,
  input wire logic       op_ready_out,
  input wire logic       done_out,
  input wire logic [7:0] result_out,
  input wire logic       result_we_out,
  input wire logic [7:0] io_data_out,
  input wire logic       io_we_out,
  input wire logic [7:0] stack_wdata_out,
  input wire logic       stack_push_out,
  input wire logic       stack_pop_out,
  input wire logic [7:0] status_register_out
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire take = op_valid_in && op_ready_out;
  wire stk = (op_code_in == BFIU_OP_PUSH) || (op_code_in == BFIU_OP_POP);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_single_done;
    take && !stk |=> done_out;
  endproperty
  a_single_done: assert property (p_single_done) else $error("op late");
  property p_push;
    take && op_code_in == BFIU_OP_PUSH |=> !op_ready_out && !done_out
      ##1 stack_push_out && done_out && stack_wdata_out == $past(reg_data_in, 2);
  endproperty
  a_push: assert property (p_push) else $error("push wrong");
  property p_pop;
    take && op_code_in == BFIU_OP_POP |=> stack_pop_out
      ##1 result_we_out && done_out && result_out == $past(stack_data_in);
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_stack_flags;
    take && stk |=> $stable(status_register_out) [*2];
  endproperty
  a_stack_flags: assert property (p_stack_flags) else $error("stack flags");
  property p_io_set;
    take && op_code_in == BFIU_OP_IO_BIT_SET |=> io_we_out
      && io_data_out == ($past(io_data_in) | (8'h01 << $past(bit_sel_in)));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io set");
  property p_io_clr;
    take && op_code_in == BFIU_OP_IO_BIT_CLEAR |=> io_we_out
      && io_data_out == ($past(io_data_in) & ~(8'h01 << $past(bit_sel_in)));
  endproperty
  a_io_clr: assert property (p_io_clr) else $error("io clear");
  property p_lsl;
    take && op_code_in == BFIU_OP_LSL |=> result_we_out
      && result_out == 8'($past(reg_data_in) << 1);
  endproperty
  a_lsl: assert property (p_lsl) else $error("shift left");
  property p_swap;
    take && op_code_in == BFIU_OP_SWAP |=> $stable(status_register_out)
      && result_out == 8'({$past(reg_data_in), $past(reg_data_in)} >> 4);
  endproperty
  a_swap: assert property (p_swap) else $error("swap");
  property p_s_flag;
    take && op_code_in inside {[BFIU_OP_LSL:BFIU_OP_ASR]}
      |=> status_register_out[4] == (status_register_out[2] ^ status_register_out[3]);
  endproperty
  a_s_flag: assert property (p_s_flag) else $error("signed flag");
endmodule

bind bfiu_core bfiu_chk_monitor u_chk (
  .clock_in(clock_in), .resetn_in(resetn_in), .op_valid_in(op_valid_in),
  .op_code_in(op_code_in), .reg_data_in(reg_data_in), .io_data_in(io_data_in),
  .bit_sel_in(bit_sel_in), .stack_data_in(stack_data_in), .op_ready_out(op_ready_out),
  .done_out(done_out), .result_out(result_out), .result_we_out(result_we_out),
  .io_data_out(io_data_out), .io_we_out(io_we_out), .stack_wdata_out(stack_wdata_out),
  .stack_push_out(stack_push_out), .stack_pop_out(stack_pop_out),
  .status_register_out(status_register_out)
);
`default_nettype wire

/* File: bfiu_core.sv */
// Execution unit for the bit, bit-test, shift, stack and flag instructions
//
// Summary of operation
// - Push writes the source byte to the stack and pop loads the destination from it, each in two cycles with no flag touched.
// - I/O bit set forces the chosen bit of the I/O byte to one and I/O bit clear forces it to zero, flags untouched.
// - Logical shifts move the byte one place left or right filling with zero and update zero, carry, negative and overflow.
// - Rotates through carry feed old carry into the vacated end and move the leaving bit into carry, updating Z, C, N, V.
// - Arithmetic right shift moves bits 7..1 down one place keeping bit 7 and updates Z, C, N, V.
// - Nibble swap exchanges the two halves of the byte and leaves every flag unchanged.
// - Selected flag set writes one and selected flag clear writes zero to the status bit chosen by the operand.
// - Bit store copies a chosen source bit into the transfer flag and bit load copies that flag into a destination bit.
// - Dedicated ops set or clear carry, and others set or clear negative, each touching only its own flag.
// - Dedicated ops set or clear the zero flag and touch no other flag.
// - Interrupt enable sets the interrupt flag and interrupt disable clears it.
// - Dedicated ops set or clear the signed-test flag and touch no other flag.
// - Dedicated ops set or clear the overflow flag and touch no other flag.
// - A dedicated op sets the transfer flag to one.
`timescale 1ns/1ps
`default_nettype none

module bfiu_core
  import bfiu_pkg::*;
(
  input  wire logic                   clock_in,
  input  wire logic                   resetn_in,
  input  wire logic                   op_valid_in,
  input  wire logic [4:0]             op_code_in,
  input  wire logic [BFIU_DATA_W-1:0] reg_data_in,
  input  wire logic [BFIU_SEL_W-1:0]  bit_sel_in,
  input  wire logic [BFIU_DATA_W-1:0] io_data_in,
  input  wire logic [BFIU_DATA_W-1:0] stack_data_in,
  output logic                        op_ready_out,
  output logic                        done_out,
  output logic [BFIU_DATA_W-1:0]      result_out,
  output logic                        result_we_out,
  output logic [BFIU_DATA_W-1:0]      io_data_out,
  output logic                        io_we_out,
  output logic [BFIU_DATA_W-1:0]      stack_wdata_out,
  output logic                        stack_push_out,
  output logic                        stack_pop_out,
  output logic [BFIU_DATA_W-1:0]      status_register_out
);

  // ------------------------------------------------------------
  // State record
  // ------------------------------------------------------------
  typedef struct packed {
    bfiu_state_e          state;
    logic                 is_pop;
    logic [BFIU_DATA_W-1:0] status_register;
    logic [BFIU_DATA_W-1:0] result;
    logic                 result_we;
    logic [BFIU_DATA_W-1:0] io_data;
    logic                 io_we;
    logic [BFIU_DATA_W-1:0] stack_wdata;
    logic                 stack_push;
    logic                 stack_pop;
    logic                 done;
  } bfiu_regs_s;

  bfiu_regs_s regs_q;
  bfiu_regs_s regs_d;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Write one bit of a byte at a run-time position
  function automatic logic [BFIU_DATA_W-1:0] bfiu_put_bit(
    input logic [BFIU_DATA_W-1:0] value,
    input logic [BFIU_SEL_W-1:0]  pos,
    input logic                   bit_val
  );
    logic [BFIU_DATA_W-1:0] tmp;
    tmp      = value;
    tmp[pos] = bit_val;
    return tmp;
  endfunction

  // Flag update shared by all shifts and rotates
  function automatic logic [BFIU_DATA_W-1:0] bfiu_shift_flags(
    input logic [BFIU_DATA_W-1:0] status,
    input logic [BFIU_DATA_W-1:0] res,
    input logic                   carry
  );
    logic [BFIU_DATA_W-1:0] tmp;
    logic                   neg;
    logic                   ovf;
    tmp              = status;
    neg              = res[BFIU_MSB];
    ovf              = neg ^ carry;
    tmp[BFIU_FLAG_Z] = (res == BFIU_BYTE_ZERO);
    tmp[BFIU_FLAG_C] = carry;
    tmp[BFIU_FLAG_N] = neg;
    tmp[BFIU_FLAG_V] = ovf;
    tmp[BFIU_FLAG_S] = neg ^ ovf;
    return tmp;
  endfunction

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------

  // Accept a new op only while idle
  logic                   take;
  logic [BFIU_DATA_W-1:0] shifted;
  // Carry before the op, fed in by the rotates
  logic                   carry_old;

  // Build the next record from the current one and the offered op
  always_comb begin
    regs_d            = regs_q;
    // Pulses fall back low every cycle; data and flags hold
    regs_d.result_we  = 1'b0;
    regs_d.io_we      = 1'b0;
    regs_d.stack_push = 1'b0;
    regs_d.stack_pop  = 1'b0;
    regs_d.done       = 1'b0;
    shifted           = BFIU_BYTE_ZERO;
    carry_old         = regs_q.status_register[BFIU_FLAG_C];
    take              = op_valid_in && (regs_q.state == BFIU_ST_IDLE);

    unique case (regs_q.state)
      BFIU_ST_IDLE: begin
        if (take) begin
          regs_d.done = 1'b1;
          // Decode the op; all but push and pop finish in this cycle
          unique case (bfiu_op_e'(op_code_in))
            // Stack ops need a second cycle for the stack to answer, and
            // the unit refuses new ops until it is idle again
            BFIU_OP_PUSH: begin
              regs_d.state       = BFIU_ST_STACK;
              regs_d.is_pop      = 1'b0;
              regs_d.stack_wdata = reg_data_in;
              regs_d.done        = 1'b0;
            end
            // Pop requests the read now and loads the byte next cycle
            BFIU_OP_POP: begin
              regs_d.state     = BFIU_ST_STACK;
              regs_d.is_pop    = 1'b1;
              regs_d.stack_pop = 1'b1;
              regs_d.done      = 1'b0;
            end
            // I/O bit ops rewrite one bit of the fetched I/O byte
            BFIU_OP_IO_BIT_SET: begin
              regs_d.io_data = bfiu_put_bit(io_data_in, bit_sel_in, 1'b1);
              regs_d.io_we   = 1'b1;
            end
            // Clear variant writes zero at the same position
            BFIU_OP_IO_BIT_CLEAR: begin
              regs_d.io_data = bfiu_put_bit(io_data_in, bit_sel_in, 1'b0);
              regs_d.io_we   = 1'b1;
            end
            // Left shift fills bit 0 with zero; the top bit leaves into carry
            BFIU_OP_LSL: begin
              shifted = {reg_data_in[BFIU_MSB-1:BFIU_LSB], 1'b0};
              regs_d.result          = shifted;
              regs_d.result_we       = 1'b1;
              regs_d.status_register = bfiu_shift_flags(regs_q.status_register, shifted,
                                                        reg_data_in[BFIU_MSB]);
            end
            // Right shift fills the top bit with zero; bit 0 leaves into carry
            BFIU_OP_LSR: begin
              shifted = {1'b0, reg_data_in[BFIU_MSB:BFIU_LSB+1]};
              regs_d.result          = shifted;
              regs_d.result_we       = 1'b1;
              regs_d.status_register = bfiu_shift_flags(regs_q.status_register, shifted,
                                                        reg_data_in[BFIU_LSB]);
            end
            // Rotate left brings the old carry in at bit 0
            BFIU_OP_ROT_LEFT: begin
              shifted = {reg_data_in[BFIU_MSB-1:BFIU_LSB], carry_old};
              regs_d.result          = shifted;
              regs_d.result_we       = 1'b1;
              regs_d.status_register = bfiu_shift_flags(regs_q.status_register, shifted,
                                                        reg_data_in[BFIU_MSB]);
            end
            // Rotate right brings the old carry in at the top bit
            BFIU_OP_ROT_RIGHT: begin
              shifted = {carry_old, reg_data_in[BFIU_MSB:BFIU_LSB+1]};
              regs_d.result          = shifted;
              regs_d.result_we       = 1'b1;
              regs_d.status_register = bfiu_shift_flags(regs_q.status_register, shifted,
                                                        reg_data_in[BFIU_LSB]);
            end
            // Arithmetic right shift keeps the sign bit in place
            BFIU_OP_ASR: begin
              shifted = {reg_data_in[BFIU_MSB], reg_data_in[BFIU_MSB:BFIU_LSB+1]};
              regs_d.result          = shifted;
              regs_d.result_we       = 1'b1;
              regs_d.status_register = bfiu_shift_flags(regs_q.status_register, shifted,
                                                        reg_data_in[BFIU_LSB]);
            end
            // Nibble swap writes the result only; flags hold
            BFIU_OP_SWAP: begin
              regs_d.result    = {reg_data_in[BFIU_NIB_LO_HI:BFIU_LSB],
                                  reg_data_in[BFIU_MSB:BFIU_NIB_HI_LO]};
              regs_d.result_we = 1'b1;
            end
            // Operand-selected status bit forced to one
            BFIU_OP_FLAG_SEL_SET: begin
              regs_d.status_register = bfiu_put_bit(regs_q.status_register,
                                                    bit_sel_in, 1'b1);
            end
            // Operand-selected status bit forced to zero
            BFIU_OP_FLAG_SEL_CLR: begin
              regs_d.status_register = bfiu_put_bit(regs_q.status_register,
                                                    bit_sel_in, 1'b0);
            end
            // Transfer flag takes the chosen source bit
            BFIU_OP_BIT_TO_T: begin
              regs_d.status_register[BFIU_FLAG_T] = reg_data_in[bit_sel_in];
            end
            // Chosen destination bit takes the transfer flag
            BFIU_OP_T_TO_BIT: begin
              regs_d.result    = bfiu_put_bit(reg_data_in, bit_sel_in,
                                              regs_q.status_register[BFIU_FLAG_T]);
              regs_d.result_we = 1'b1;
            end
            // Dedicated flag ops each touch their own bit only
            BFIU_OP_CARRY_SET:   regs_d.status_register[BFIU_FLAG_C] = 1'b1;
            BFIU_OP_CARRY_CLR:   regs_d.status_register[BFIU_FLAG_C] = 1'b0;
            BFIU_OP_NEG_SET:     regs_d.status_register[BFIU_FLAG_N] = 1'b1;
            BFIU_OP_NEG_CLR:     regs_d.status_register[BFIU_FLAG_N] = 1'b0;
            BFIU_OP_ZERO_SET:    regs_d.status_register[BFIU_FLAG_Z] = 1'b1;
            BFIU_OP_ZERO_CLR:    regs_d.status_register[BFIU_FLAG_Z] = 1'b0;
            BFIU_OP_INT_ENABLE:  regs_d.status_register[BFIU_FLAG_I] = 1'b1;
            BFIU_OP_INT_DISABLE: regs_d.status_register[BFIU_FLAG_I] = 1'b0;
            BFIU_OP_SIGNED_SET:  regs_d.status_register[BFIU_FLAG_S] = 1'b1;
            BFIU_OP_SIGNED_CLR:  regs_d.status_register[BFIU_FLAG_S] = 1'b0;
            BFIU_OP_OVF_SET:     regs_d.status_register[BFIU_FLAG_V] = 1'b1;
            BFIU_OP_OVF_CLR:     regs_d.status_register[BFIU_FLAG_V] = 1'b0;
            BFIU_OP_T_SET:       regs_d.status_register[BFIU_FLAG_T] = 1'b1;
            default: begin
              // Unknown or empty code: acknowledged, nothing changes
              regs_d.done = 1'b1;
            end
          endcase
        end
      end
      BFIU_ST_STACK: begin
        // Second cycle of push or pop; flags left alone
        regs_d.state = BFIU_ST_IDLE;
        regs_d.done  = 1'b1;
        // Pop loads the byte the stack shows now; push raises its strobe
        if (regs_q.is_pop) begin
          regs_d.result    = stack_data_in;
          regs_d.result_we = 1'b1;
        end else begin
          regs_d.stack_push = 1'b1;
        end
      end
      default: begin
        // Illegal one-hot code recovers to idle
        regs_d.state = BFIU_ST_IDLE;
      end
    endcase
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------

  // Register the whole state record
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      // Idle, flags cleared, every pulse low
      regs_q.state           <= BFIU_ST_IDLE;
      regs_q.is_pop          <= 1'b0;
      regs_q.status_register <= BFIU_STATUS_RESET;
      regs_q.result          <= BFIU_BYTE_ZERO;
      regs_q.result_we       <= 1'b0;
      regs_q.io_data         <= BFIU_BYTE_ZERO;
      regs_q.io_we           <= 1'b0;
      regs_q.stack_wdata     <= BFIU_BYTE_ZERO;
      regs_q.stack_push      <= 1'b0;
      regs_q.stack_pop       <= 1'b0;
      regs_q.done            <= 1'b0;
    end else begin
      regs_q <= regs_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------

  // Handshake is combinational, data comes from flip-flops
  assign op_ready_out        = (regs_q.state == BFIU_ST_IDLE);
  assign done_out            = regs_q.done;
  assign result_out          = regs_q.result;
  assign result_we_out       = regs_q.result_we;
  assign io_data_out         = regs_q.io_data;
  assign io_we_out           = regs_q.io_we;
  assign stack_wdata_out     = regs_q.stack_wdata;
  assign stack_push_out      = regs_q.stack_push;
  assign stack_pop_out       = regs_q.stack_pop;
  assign status_register_out = regs_q.status_register;

endmodule

`default_nettype wire

/* File: bfiu_pkg.sv */
// Package of constants and types for the bit and flag instruction unit
package bfiu_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned BFIU_DATA_W = 8;
  localparam int unsigned BFIU_SEL_W  = 3;

  // ------------------------------------------------------------
  // Status register bit positions
  // ------------------------------------------------------------
  localparam int unsigned BFIU_FLAG_C = 0;
  localparam int unsigned BFIU_FLAG_Z = 1;
  localparam int unsigned BFIU_FLAG_N = 2;
  localparam int unsigned BFIU_FLAG_V = 3;
  localparam int unsigned BFIU_FLAG_S = 4;
  localparam int unsigned BFIU_FLAG_H = 5;
  localparam int unsigned BFIU_FLAG_T = 6;
  localparam int unsigned BFIU_FLAG_I = 7;

  // ------------------------------------------------------------
  // Reset values and fixed data
  // ------------------------------------------------------------
  localparam logic [7:0] BFIU_STATUS_RESET = 8'h00;
  localparam logic [7:0] BFIU_BYTE_ZERO    = 8'h00;
  localparam int unsigned BFIU_MSB         = 7;
  localparam int unsigned BFIU_LSB         = 0;
  localparam int unsigned BFIU_NIB_LO_HI   = 3;
  localparam int unsigned BFIU_NIB_HI_LO   = 4;

  // ------------------------------------------------------------
  // Operation codes presented by the decoder
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    BFIU_OP_NONE          = 5'h00,
    BFIU_OP_PUSH          = 5'h01,
    BFIU_OP_POP           = 5'h02,
    BFIU_OP_IO_BIT_SET    = 5'h03,
    BFIU_OP_IO_BIT_CLEAR  = 5'h04,
    BFIU_OP_LSL           = 5'h05,
    BFIU_OP_LSR           = 5'h06,
    BFIU_OP_ROT_LEFT      = 5'h07,
    BFIU_OP_ROT_RIGHT     = 5'h08,
    BFIU_OP_ASR           = 5'h09,
    BFIU_OP_SWAP          = 5'h0A,
    BFIU_OP_FLAG_SEL_SET  = 5'h0B,
    BFIU_OP_FLAG_SEL_CLR  = 5'h0C,
    BFIU_OP_BIT_TO_T      = 5'h0D,
    BFIU_OP_T_TO_BIT      = 5'h0E,
    BFIU_OP_CARRY_SET     = 5'h0F,
    BFIU_OP_CARRY_CLR     = 5'h10,
    BFIU_OP_NEG_SET       = 5'h11,
    BFIU_OP_NEG_CLR       = 5'h12,
    BFIU_OP_ZERO_SET      = 5'h13,
    BFIU_OP_ZERO_CLR      = 5'h14,
    BFIU_OP_INT_ENABLE    = 5'h15,
    BFIU_OP_INT_DISABLE   = 5'h16,
    BFIU_OP_SIGNED_SET    = 5'h17,
    BFIU_OP_SIGNED_CLR    = 5'h18,
    BFIU_OP_OVF_SET       = 5'h19,
    BFIU_OP_OVF_CLR       = 5'h1A,
    BFIU_OP_T_SET         = 5'h1B
  } bfiu_op_e;

  // ------------------------------------------------------------
  // Sequencer states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    BFIU_ST_IDLE  = 2'b01,
    BFIU_ST_STACK = 2'b10
  } bfiu_state_e;

endpackage

/* File: bfiu_stack_model.sv */
// Stack memory model standing beside the unit
`timescale 1ns/1ps
`default_nettype none
module bfiu_stack_model (
  input  wire logic       clock_in,
  input  wire logic       resetn_in,
  input  wire logic       push_in,
  input  wire logic       pop_in,
  input  wire logic [7:0] wdata_in,
  output logic      [7:0] rdata_out
);
  logic [7:0] mem [0:7];
  logic [2:0] sp_q;
  logic [7:0] last_q;
  // Read data valid only while pop strobe is high; else a toggling pattern
  assign rdata_out = pop_in ? mem[sp_q - 3'h1] : ~last_q;
  // Stack pointer and storage
  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sp_q <= 3'h0;
      last_q <= 8'h00;
    end else begin
      last_q <= pop_in ? mem[sp_q - 3'h1] : ~last_q;
      if (push_in) begin
        mem[sp_q] <= wdata_in;
        sp_q <= sp_q + 3'h1;
      end
      if (pop_in)
        sp_q <= sp_q - 3'h1;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Self-checking testbench for the bit and flag instruction unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bfiu_pkg::*;
  logic       clock_in = 1'b0;
  logic       resetn_in, op_valid_in, op_ready_out, done_out, result_we_out;
  logic       io_we_out, stack_push_out, stack_pop_out;
  logic [4:0] op_code_in;
  logic [2:0] bit_sel_in;
  logic [7:0] reg_data_in, io_data_in, stack_data_in, result_out, io_data_out;
  logic [7:0] stack_wdata_out, status_register_out, exp_sr;
  int         miscompares = 0, cmp_count = 0, cycles = 0;

  // ----------------------------------------
  // Clock, timeout, instances
  // ----------------------------------------
  always #5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      test_done();
    end
  end
  bfiu_core u_dut (
    .clock_in(clock_in), .resetn_in(resetn_in), .op_valid_in(op_valid_in),
    .op_code_in(op_code_in), .reg_data_in(reg_data_in), .bit_sel_in(bit_sel_in),
    .io_data_in(io_data_in), .stack_data_in(stack_data_in), .op_ready_out(op_ready_out),
    .done_out(done_out), .result_out(result_out), .result_we_out(result_we_out),
    .io_data_out(io_data_out), .io_we_out(io_we_out), .stack_wdata_out(stack_wdata_out),
    .stack_push_out(stack_push_out), .stack_pop_out(stack_pop_out),
    .status_register_out(status_register_out));
  bfiu_stack_model u_stack (.clock_in(clock_in), .resetn_in(resetn_in),
    .push_in(stack_push_out), .pop_in(stack_pop_out), .wdata_in(stack_wdata_out),
    .rdata_out(stack_data_in));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One op; waits for done and checks its latency
  task automatic issue(input bfiu_op_e c, input logic [7:0] r, input logic [2:0] s,
                       input logic [7:0] io);
    int n;
    @(posedge clock_in);
    op_valid_in <= 1'b1;
    op_code_in <= c;
    reg_data_in <= r;
    bit_sel_in <= s;
    io_data_in <= io;
    @(posedge clock_in);
    op_valid_in <= 1'b0;
    n = 1;
    #1;
    while (done_out !== 1'b1 && n < 4) begin
      @(posedge clock_in);
      #1;
      n++;
    end
    chk(8'(n), (c == BFIU_OP_PUSH || c == BFIU_OP_POP) ? 8'h02 : 8'h01);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_flags();
    bfiu_op_e fo[13] = '{BFIU_OP_CARRY_SET, BFIU_OP_NEG_SET, BFIU_OP_ZERO_SET,
      BFIU_OP_INT_ENABLE, BFIU_OP_SIGNED_SET, BFIU_OP_OVF_SET, BFIU_OP_T_SET,
      BFIU_OP_CARRY_CLR, BFIU_OP_NEG_CLR, BFIU_OP_ZERO_CLR, BFIU_OP_INT_DISABLE,
      BFIU_OP_SIGNED_CLR, BFIU_OP_OVF_CLR};
    int fb[13] = '{0, 2, 1, 7, 4, 3, 6, 0, 2, 1, 7, 4, 3};
    for (int i = 0; i < 13; i++) begin
      exp_sr[fb[i]] = (i < 7);
      issue(fo[i], 8'h00, 3'h0, 8'h00);
      chk(status_register_out, exp_sr);
    end
    for (int s = 0; s < 16; s++) begin
      exp_sr[s%8] = (s < 8);
      if (s < 8 || s[0])
        issue(s < 8 ? BFIU_OP_FLAG_SEL_SET : BFIU_OP_FLAG_SEL_CLR, 8'h00, 3'(s), 8'h00);
      else
        exp_sr[s%8] = 1'b1;
      chk(status_register_out, exp_sr);
    end
  endtask
  task automatic t_stack();
    issue(BFIU_OP_PUSH, 8'hA5, 3'h0, 8'h00);
    chk(stack_wdata_out, 8'hA5);
    issue(BFIU_OP_PUSH, 8'h3C, 3'h0, 8'h00);
    issue(BFIU_OP_POP, 8'h00, 3'h0, 8'h00);
    chk(result_out, 8'h3C);
    issue(BFIU_OP_POP, 8'h00, 3'h0, 8'h00);
    chk(result_out, 8'hA5);
    chk(status_register_out, exp_sr);
  endtask
  task automatic t_io();
    issue(BFIU_OP_IO_BIT_SET, 8'h00, 3'h7, 8'h00);
    chk(io_data_out, 8'h80);
    issue(BFIU_OP_IO_BIT_CLEAR, 8'h00, 3'h0, 8'hFF);
    chk(io_data_out, 8'hFE);
    chk(status_register_out, exp_sr);
  endtask
  task automatic t_shift();
    bfiu_op_e so[7] = '{BFIU_OP_LSL, BFIU_OP_LSR, BFIU_OP_ROT_LEFT, BFIU_OP_ROT_RIGHT,
      BFIU_OP_ROT_RIGHT, BFIU_OP_ASR, BFIU_OP_LSL};
    logic [7:0] si[7] = '{8'h81, 8'h01, 8'h80, 8'h01, 8'h02, 8'h81, 8'h40};
    logic [7:0] rs[7] = '{8'h02, 8'h00, 8'h01, 8'h80, 8'h01, 8'hC0, 8'h80};
    logic [6:0] ci = 7'h4C;
    logic [6:0] co = 7'h2F;
    for (int i = 0; i < 7; i++) begin
      exp_sr[0] = ci[i];
      issue(ci[i] ? BFIU_OP_CARRY_SET : BFIU_OP_CARRY_CLR, 8'h00, 3'h0, 8'h00);
      issue(so[i], si[i], 3'h0, 8'h00);
      exp_sr[0] = co[i];
      exp_sr[1] = (rs[i] == 8'h00);
      exp_sr[2] = rs[i][7];
      exp_sr[3] = rs[i][7] ^ co[i];
      exp_sr[4] = exp_sr[2] ^ exp_sr[3];
      chk(result_out, rs[i]);
      chk(status_register_out, exp_sr);
    end
  endtask
  task automatic t_swap_bits();
    issue(BFIU_OP_SWAP, 8'h3C, 3'h0, 8'h00);
    chk(result_out, 8'hC3);
    chk(status_register_out, exp_sr);
    issue(BFIU_OP_BIT_TO_T, 8'h10, 3'h4, 8'h00);
    exp_sr[6] = 1'b1;
    chk(status_register_out, exp_sr);
    issue(BFIU_OP_T_TO_BIT, 8'h00, 3'h5, 8'h00);
    chk(result_out, 8'h20);
    issue(BFIU_OP_BIT_TO_T, 8'hEF, 3'h4, 8'h00);
    exp_sr[6] = 1'b0;
    issue(BFIU_OP_T_TO_BIT, 8'hFF, 3'h0, 8'h00);
    chk(result_out, 8'hFE);
    chk(status_register_out, exp_sr);
  endtask
  task automatic t_b2b();
    @(posedge clock_in);
    op_valid_in <= 1'b1;
    op_code_in <= BFIU_OP_CARRY_CLR;
    @(posedge clock_in);
    op_code_in <= BFIU_OP_OVF_SET;
    @(posedge clock_in);
    op_valid_in <= 1'b0;
    #1;
    exp_sr[0] = 1'b0;
    exp_sr[3] = 1'b1;
    chk(8'(done_out), 8'h01);
    chk(status_register_out, exp_sr);
  endtask
  task automatic t_busy();
    @(posedge clock_in);
    op_valid_in <= 1'b1;
    op_code_in <= BFIU_OP_PUSH;
    reg_data_in <= 8'h5A;
    @(posedge clock_in);
    op_code_in <= BFIU_OP_ZERO_SET;
    #1;
    chk(8'(op_ready_out), 8'h00);
    @(posedge clock_in);
    #1;
    chk(8'(done_out), 8'h01);
    chk(status_register_out, exp_sr);
    @(posedge clock_in);
    op_valid_in <= 1'b0;
    #1;
    exp_sr[1] = 1'b1;
    chk(8'(done_out), 8'h01);
    chk(status_register_out, exp_sr);
    issue(BFIU_OP_POP, 8'h00, 3'h0, 8'h00);
    chk(result_out, 8'h5A);
    issue(bfiu_op_e'(5'h1F), 8'h00, 3'h0, 8'h00);
    chk(status_register_out, exp_sr);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    resetn_in = 1'b0;
    op_valid_in = 1'b0;
    op_code_in = 5'h00;
    reg_data_in = 8'h00;
    bit_sel_in = 3'h0;
    io_data_in = 8'h00;
    exp_sr = 8'h00;
    repeat (6) @(posedge clock_in);
    resetn_in <= 1'b1;
    #1;
    chk(status_register_out, 8'h00);
    chk(8'(op_ready_out), 8'h01);
    t_flags();
    t_stack();
    t_io();
    t_shift();
    t_swap_bits();
    t_b2b();
    t_busy();
    test_done();
  end
endmodule
`default_nettype wire
